// ---- hdl/modbus_config_io_registers.sv ----
// Purpose: Configuration and I/O register bank of a room controller.
// Assumes: A protocol engine on ref_clk issues register accesses and frame events.
// Notes:   Pins pass a two-flop synchroniser before use.
`timescale 1ns/1ps
`include "modbus_cfg_params.svh"

// Function
// - Bit rate setting writes take effect only after the next restart.
// - Identity word: module type in low byte, firmware version times ten high.
// - Action 511 resets the module; 767 reloads stored settings.
// - Action 1023 restores factory defaults; 1279 enters the bootloader.
// - Station address register reads the address switch, read only.
// - 32-bit counter of valid received request frames.
// - All frame counters clear at power-up and on transmission parameter change.
// - 32-bit counter of error replies sent.
// - 32-bit counter of reply frames transmitted.
// - 16-bit seconds counter since power-up or reset.
// - With speed switch sections 1-3 off, bit rate is setting times ten.
// - One stop bit, eight data bits; registers read 1 and 8.
// - No parity; parity register reads 0.
// - Reply waits the programmed milliseconds; 0 means just the silent interval.
// - Mirror bits 0 and 6 select latching wall switches per input pair.
// - Mirror bits 1 and 3 route wall input one or two to both lights.
// - Mirror bits 2 and 4 route presence input one or two to both lights.
// - Mirror bit 5 selects on/off lighting, else lighting bus control.
// - Mirror bit 7 selects plain blinds, else shutters with slats.
// - Relay word bits 0 and 1 show lamp relays one and two closed.
// - Relay word bits 2 and 3 show raise and lower relays closed.
// - Input word bits 0 to 3 show wall inputs one to four closed.
module modbus_config_io_registers
  import modbus_cfg_pkg::*;
#(
  parameter logic [7:0] MODULE_TYPE   = 8'h5A,  // Arbitrary value.
  parameter logic [7:0] FW_VERSION_X10 = 8'h0C,
  parameter int         CYCLES_PER_SEC = `CYC_PER_SECOND,
  parameter int         CYCLES_PER_MS  = `CYC_PER_MS
)(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_ack,
  output logic             reg_err,
  input  wire logic        rx_frame_ok,
  input  wire logic        err_reply_sent,
  input  wire logic        tx_frame_sent,
  input  wire logic        reply_request,
  output logic             reply_go,
  input  wire logic [7:0]  station_address_switch,
  input  wire logic [7:0]  config_switch_pins,
  input  wire logic [2:0]  speed_select_switch,
  input  wire logic [3:0]  wall_inputs,
  input  wire logic [1:0]  presence_inputs,
  input  wire logic [3:0]  relay_feedback,
  output logic [31:0]      serial_bit_rate,
  output logic             rate_from_switch,
  output logic             module_reset_req,
  output logic             reload_req,
  output logic             defaults_req,
  output logic             boot_req,
  output logic             light_one_demand,
  output logic             light_two_demand,
  output logic             wall_pair_a_latching,
  output logic             wall_pair_b_latching,
  output logic             on_off_light_mode,
  output logic             slat_control
);

  // ==========================================================
  // Pin synchroniser
  localparam int PINS = 29;
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;
  wire  [PINS-1:0] pin_raw = {station_address_switch, config_switch_pins, speed_select_switch,
                              wall_inputs, presence_inputs, relay_feedback};

  always_ff @(posedge ref_clk)
  begin
    pin_meta <= pin_raw;
    pin_sync <= pin_meta;
  end

  wire [7:0] station_sync = pin_sync[28:21];
  wire [7:0] config_switch_mirror = pin_sync[20:13];
  wire [2:0] speed_sync = pin_sync[12:10];
  wire [3:0] wall_sync = pin_sync[9:6];
  wire [1:0] pres_sync = pin_sync[5:4];
  wire [3:0] relay_sync = pin_sync[3:0];

  // ==========================================================
  // Write decode
  wire wr_action = reg_wr && (reg_addr == `ADR_ACTION);
  wire wr_rate   = reg_wr && (reg_addr == `ADR_BIT_RATE);
  wire wr_wait   = reg_wr && (reg_addr == `ADR_ANSWER_WAIT);
  wire act_reset = wr_action && (reg_wdata == `ACT_RESET);
  wire act_reload = wr_action && (reg_wdata == `ACT_RELOAD);
  wire act_defaults = wr_action && (reg_wdata == `ACT_DEFAULTS);
  wire act_boot  = wr_action && (reg_wdata == `ACT_BOOT);

  // ==========================================================
  // Settings
  word_t bit_rate_setting;
  word_t answer_wait_ms;
  word_t active_rate;
  logic [2:0] speed_prev;

  wire word_t next_rate = act_defaults ? `RST_BIT_RATE : (wr_rate ? reg_wdata : bit_rate_setting);
  // A restart is where new transmission settings are adopted.
  wire restart_now = act_reset;
  // Parameter change: a stored rate that differs, or a moved speed switch.
  wire param_change = (next_rate != bit_rate_setting) || (speed_sync != speed_prev);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      bit_rate_setting <= `RST_BIT_RATE;
      answer_wait_ms   <= `RST_ANSWER_WAIT;
      active_rate      <= `RST_BIT_RATE;
      speed_prev       <= 3'h0;
    end
    else
    begin
      bit_rate_setting <= next_rate;
      speed_prev       <= speed_sync;
      if (act_defaults)
        answer_wait_ms <= `RST_ANSWER_WAIT;
      else if (wr_wait)
        answer_wait_ms <= reg_wdata;
      if (restart_now)
        active_rate <= bit_rate_setting;
    end
  end

  // A set speed switch raises rate_from_switch at once; serial_bit_rate follows only the register path, after restart.
  assign rate_from_switch = (speed_sync != 3'h0);
  assign serial_bit_rate = {16'h0000, active_rate} * `RATE_SCALE;

  // ==========================================================
  // Action pulses
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      module_reset_req <= 1'b0;
      reload_req       <= 1'b0;
      defaults_req     <= 1'b0;
      boot_req         <= 1'b0;
    end
    else
    begin
      module_reset_req <= act_reset;
      reload_req       <= act_reload;
      defaults_req     <= act_defaults;
      boot_req         <= act_boot;
    end
  end

  // ==========================================================
  // Frame counters
  count_t rx_count;
  count_t err_count;
  count_t tx_count;
  wire clear_counts = param_change;

  // A clear in the same cycle as an event leaves the event counted.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rx_count  <= 32'h0000_0000;
      err_count <= 32'h0000_0000;
      tx_count  <= 32'h0000_0000;
    end
    else
    begin
      rx_count  <= (clear_counts ? 32'h0000_0000 : rx_count) + {31'h0, rx_frame_ok};
      err_count <= (clear_counts ? 32'h0000_0000 : err_count) + {31'h0, err_reply_sent};
      tx_count  <= (clear_counts ? 32'h0000_0000 : tx_count) + {31'h0, tx_frame_sent};
    end
  end

  // ==========================================================
  // Uptime
  logic [31:0] sec_prescale;
  word_t       seconds_since_boot;
  wire         sec_tick = (sec_prescale == 32'(CYCLES_PER_SEC - 1));

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || restart_now)
    begin
      sec_prescale       <= 32'h0000_0000;
      seconds_since_boot <= 16'h0000;
    end
    else
    begin
      sec_prescale       <= sec_tick ? 32'h0000_0000 : sec_prescale + 32'h0000_0001;
      seconds_since_boot <= seconds_since_boot + {15'h0000, sec_tick};
    end
  end

  // ==========================================================
  // Reply delay
  wait_state_e wait_state;
  logic [31:0] ms_prescale;
  word_t       ms_left;
  wire         ms_tick = (ms_prescale == 32'(CYCLES_PER_MS - 1));
  wire         start_now = (wait_state == WAIT_IDLE) && reply_request && (answer_wait_ms == 16'h0000);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wait_state  <= WAIT_IDLE;
      ms_prescale <= 32'h0000_0000;
      ms_left     <= 16'h0000;
      reply_go    <= 1'b0;
    end
    else
    begin
      reply_go <= 1'b0;
      case (wait_state)
        WAIT_IDLE:
        begin
          ms_prescale <= 32'h0000_0000;
          ms_left     <= answer_wait_ms;
          if (start_now)
            reply_go <= 1'b1;
          else if (reply_request)
            wait_state <= WAIT_RUN;
        end
        WAIT_RUN:
        begin
          ms_prescale <= ms_tick ? 32'h0000_0000 : ms_prescale + 32'h0000_0001;
          if (ms_tick)
          begin
            ms_left <= ms_left - 16'h0001;
            if (ms_left == 16'h0001)
            begin
              reply_go   <= 1'b1;
              wait_state <= WAIT_IDLE;
            end
          end
        end
        default: wait_state <= WAIT_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Switch-driven behaviour
  wire [7:0] cfg = config_switch_mirror;
  assign wall_pair_a_latching = cfg[`CFG_PAIR_A_LATCH];
  assign wall_pair_b_latching = cfg[`CFG_PAIR_B_LATCH];
  assign light_one_demand = wall_sync[0] | (wall_sync[1] & cfg[`CFG_WALL_TWO])
                          | pres_sync[0] | (pres_sync[1] & cfg[`CFG_PRES_TWO]);
  assign light_two_demand = wall_sync[1] | (wall_sync[0] & cfg[`CFG_WALL_ONE])
                          | pres_sync[1] | (pres_sync[0] & cfg[`CFG_PRES_ONE]);
  assign on_off_light_mode = cfg[`CFG_ON_OFF];
  assign slat_control = ~cfg[`CFG_BLIND_PLAIN];

  // ==========================================================
  // Read path
  word_t  count_high_shadow;
  word_t  next_rdata;
  logic   rd_known;
  logic   hi_read;
  count_t snap;

  always_comb
  begin
    next_rdata = 16'h0000;
    rd_known   = 1'b1;
    hi_read    = 1'b0;
    snap       = 32'h0000_0000;
    case (reg_addr)
      `ADR_IDENTITY:    next_rdata = {FW_VERSION_X10, MODULE_TYPE};
      `ADR_STATION:     next_rdata = {8'h00, station_sync};
      `ADR_CFG_LOW:     next_rdata = {8'h00, cfg};
      `ADR_CFG_MIRROR:  next_rdata = {8'h00, cfg};
      `ADR_RX_COUNT:    snap = rx_count;
      `ADR_ERR_COUNT:   snap = err_count;
      `ADR_TX_COUNT:    snap = tx_count;
      `ADR_RX_COUNT + 16'h0001,
      `ADR_ERR_COUNT + 16'h0001,
      `ADR_TX_COUNT + 16'h0001: hi_read = 1'b1;
      `ADR_UPTIME:      next_rdata = seconds_since_boot;
      `ADR_STOP_BITS:   next_rdata = `VAL_STOP_BITS;
      `ADR_DATA_BITS:   next_rdata = `VAL_DATA_BITS;
      `ADR_PARITY:      next_rdata = `VAL_PARITY;
      `ADR_INPUT_STATE: next_rdata = {12'h000, wall_sync};
      `ADR_RELAY_STATE: next_rdata = {12'h000, relay_sync};
      `ADR_BIT_RATE:    next_rdata = bit_rate_setting;
      `ADR_ANSWER_WAIT: next_rdata = answer_wait_ms;
      default:          rd_known = 1'b0;
    endcase
    if (reg_addr == `ADR_RX_COUNT || reg_addr == `ADR_ERR_COUNT || reg_addr == `ADR_TX_COUNT)
      next_rdata = snap[15:0];
    if (hi_read)
      next_rdata = count_high_shadow;
  end

  wire is_low_half = (reg_addr == `ADR_RX_COUNT) || (reg_addr == `ADR_ERR_COUNT)
                   || (reg_addr == `ADR_TX_COUNT);
  wire wr_known = (reg_addr == `ADR_ACTION) || (reg_addr == `ADR_BIT_RATE)
                || (reg_addr == `ADR_ANSWER_WAIT);
  wire rd_ok = rd_known && (reg_addr != `ADR_ACTION);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata         <= 16'h0000;
      reg_ack           <= 1'b0;
      reg_err           <= 1'b0;
      count_high_shadow <= 16'h0000;
    end
    else
    begin
      reg_ack <= reg_rd || reg_wr;
      reg_err <= (reg_rd && !rd_ok) || (reg_wr && !wr_known);
      if (reg_rd)
        reg_rdata <= rd_ok ? next_rdata : 16'h0000;
      if (reg_rd && is_low_half)
        count_high_shadow <= snap[31:16];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_RATE_HOLD: assert property (!restart_now |=> $stable(active_rate))
    else $error("active bit rate changed without restart");
  AST_IDENTITY: assert property (reg_rd && reg_addr == `ADR_IDENTITY |=>
    reg_ack && reg_rdata == {FW_VERSION_X10, MODULE_TYPE})
    else $error("identity word wrong");
  AST_RESET_ACT: assert property (act_reset ##1 !act_reset |-> module_reset_req ##1 !module_reset_req)
    else $error("reset action not a single pulse");
  AST_BOOT_ACT: assert property (reg_wr && reg_addr == `ADR_ACTION && reg_wdata == 16'h04FF
    |=> boot_req && !defaults_req)
    else $error("boot action missing");
  AST_RX_COUNT: assert property (rx_frame_ok && !clear_counts |=> rx_count == $past(rx_count) + 1)
    else $error("received frame not counted");
  AST_CLEAR: assert property (param_change && !err_reply_sent && !tx_frame_sent
    |=> err_count == 0 && tx_count == 0)
    else $error("counters not cleared on parameter change");
  AST_ERR_COUNT: assert property (!err_reply_sent && !clear_counts |=> $stable(err_count))
    else $error("error counter moved without event");
  AST_TX_COUNT: assert property (tx_frame_sent && !clear_counts |=> tx_count == $past(tx_count) + 1)
    else $error("transmitted frame not counted");
  AST_STOP: assert property (reg_rd && reg_addr == `ADR_STOP_BITS |=> reg_rdata == 16'h0001)
    else $error("stop bits not one");
  AST_PARITY: assert property (reg_rd && reg_addr == `ADR_PARITY |=> reg_rdata == 16'h0000)
    else $error("parity not zero");
  AST_NO_WAIT: assert property (start_now ##1 !start_now |-> reply_go ##1 !reply_go)
    else $error("zero delay reply not immediate");
  AST_SHADOW: assert property (reg_rd && reg_addr == `ADR_TX_COUNT
    |=> count_high_shadow == $past(tx_count[31:16]))
    else $error("high half not captured with low half");

  COV_RX: cover property (rx_frame_ok ##1 reg_rd && reg_addr == `ADR_RX_COUNT);
  COV_WAIT: cover property (wait_state == WAIT_RUN ##[1:300] reply_go);
  COV_DEFAULTS: cover property (act_defaults ##1 defaults_req);

endmodule : modbus_config_io_registers

// ---- hdl/modbus_cfg_params.svh ----
// Purpose: Constants of the room controller register bank.
// Assumes: Register addresses are the 16-bit protocol addresses.
// Notes:   Times are in nanoseconds; cycle counts derive from them.
`ifndef MODBUS_CFG_PARAMS_SVH
`define MODBUS_CFG_PARAMS_SVH

// ==========================================================
// Register addresses
`define ADR_IDENTITY     16'h7531
`define ADR_STATION      16'h7532
`define ADR_CFG_LOW      16'h7533
`define ADR_RX_COUNT     16'h7534
`define ADR_ERR_COUNT    16'h7536
`define ADR_TX_COUNT     16'h7538
`define ADR_UPTIME       16'h753C
`define ADR_STOP_BITS    16'h7542
`define ADR_DATA_BITS    16'h7543
`define ADR_PARITY       16'h7544
`define ADR_INPUT_STATE  16'h7559
`define ADR_RELAY_STATE  16'h755A
`define ADR_CFG_MIRROR   16'h75CC
`define ADR_ACTION       16'h9C41
`define ADR_BIT_RATE     16'h9C51
`define ADR_ANSWER_WAIT  16'h9C55

// ==========================================================
// Reset values and constant fields
`define RST_BIT_RATE     16'h1E00
`define RST_ANSWER_WAIT  16'h0000
`define VAL_STOP_BITS    16'h0001
`define VAL_DATA_BITS    16'h0008
`define VAL_PARITY       16'h0000
`define RATE_SCALE       32'h0000_000A

// ==========================================================
// Device action codes
`define ACT_RESET        16'h01FF
`define ACT_RELOAD       16'h02FF
`define ACT_DEFAULTS     16'h03FF
`define ACT_BOOT         16'h04FF

// ==========================================================
// Mirror bit positions
`define CFG_PAIR_A_LATCH 0
`define CFG_WALL_ONE     1
`define CFG_PRES_ONE     2
`define CFG_WALL_TWO     3
`define CFG_PRES_TWO     4
`define CFG_ON_OFF       5
`define CFG_PAIR_B_LATCH 6
`define CFG_BLIND_PLAIN  7

// ==========================================================
// Timing
`define CLK_PERIOD_NS    50
`define SECOND_NS        1000000000
`define MILLISECOND_NS   1000000
`define CYC_PER_SECOND   (`SECOND_NS / `CLK_PERIOD_NS)
`define CYC_PER_MS       (`MILLISECOND_NS / `CLK_PERIOD_NS)

`endif

// ---- hdl/modbus_cfg_pkg.sv ----
// Purpose: Types of the room controller register bank.
// Assumes: Constants live in modbus_cfg_params.svh.
// Notes:   None.
package modbus_cfg_pkg;
  typedef logic [15:0] word_t;
  typedef logic [31:0] count_t;
  typedef enum logic {WAIT_IDLE, WAIT_RUN} wait_state_e;
endpackage : modbus_cfg_pkg

// ---- dv/modbus_master_model.sv ----
// Purpose: Frame event source standing in for the bus master side.
// Assumes: The bench asks for one frame event per cycle that it holds a bit of send high.
// Notes:   Events come out one clock after the request, as a real frame engine would.
`timescale 1ns/1ps
module modbus_master_model (
  input  wire logic       ref_clk,
  input  wire logic [2:0] send,
  output logic            rx_frame_ok,
  output logic            err_reply_sent,
  output logic            tx_frame_sent
);
  initial {tx_frame_sent, err_reply_sent, rx_frame_ok} = 3'h0;
  always @(posedge ref_clk)
  begin
    {tx_frame_sent, err_reply_sent, rx_frame_ok} <= send;
  end
endmodule : modbus_master_model

// ---- dv/modbus_config_io_registers_bench.sv ----
// Purpose: Self-checking bench of the room controller register bank.
// Assumes: Short second and millisecond counts keep the run brief.
// Notes:   Pin changes are given four clocks to pass the synchroniser.
`timescale 1ns/1ps
`include "modbus_cfg_params.svh"
module modbus_config_io_registers_bench;
  import modbus_cfg_pkg::*;
  localparam int         CPS     = 10;
  localparam int         CPM     = 4;
  localparam logic [7:0] TYPE_ID = 8'h3C;  // Arbitrary value.
  localparam logic [7:0] FW_X10  = 8'h0F;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0, reply_request = 1'b0;
  word_t       reg_addr = 16'h0000, reg_wdata = 16'h0000, q;
  logic [7:0]  station_address_switch = 8'h00, config_switch_pins = 8'h00;
  logic [3:0]  wall_inputs = 4'h0, relay_feedback = 4'h0;
  logic [2:0]  speed_select_switch = 3'h0, send = 3'h0;
  logic [1:0]  presence_inputs = 2'h0;
  word_t       reg_rdata;
  logic        reg_ack, reg_err, rx_frame_ok, err_reply_sent, tx_frame_sent, reply_go, rate_from_switch;
  logic        module_reset_req, reload_req, defaults_req, boot_req, light_one_demand, light_two_demand;
  logic        wall_pair_a_latching, wall_pair_b_latching, on_off_light_mode, slat_control;
  logic [31:0] serial_bit_rate;
  int          mismatches = 0, n_tests = 0, cycles = 0, cnt[3], k;
  word_t       acts[4] = '{16'h01FF, 16'h02FF, 16'h03FF, 16'h04FF};

  modbus_config_io_registers #(.MODULE_TYPE(TYPE_ID), .FW_VERSION_X10(FW_X10), .CYCLES_PER_SEC(CPS),
    .CYCLES_PER_MS(CPM)) i_dut (.ref_clk, .sys_rst, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_ack, .reg_err, .rx_frame_ok, .err_reply_sent, .tx_frame_sent, .reply_request, .reply_go,
    .station_address_switch, .config_switch_pins, .speed_select_switch, .wall_inputs, .presence_inputs,
    .relay_feedback, .serial_bit_rate, .rate_from_switch, .module_reset_req, .reload_req, .defaults_req,
    .boot_req, .light_one_demand, .light_two_demand, .wall_pair_a_latching, .wall_pair_b_latching,
    .on_off_light_mode, .slat_control);
  modbus_master_model i_master (.ref_clk, .send, .rx_frame_ok, .err_reply_sent, .tx_frame_sent);

  always #25 ref_clk = ~ref_clk;

  // ==========================================================
  // Checking and bus tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input word_t a, input word_t d, input logic ee, output word_t r);
    @(posedge ref_clk);
    reg_rd <= !w;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    r = reg_rdata;
    chk("ack", 1, reg_ack);
    chk($sformatf("err %h", a), ee, reg_err);
  endtask : bus

  task automatic rchk(input word_t a, input word_t e);
    word_t r;
    bus(1'b0, a, 16'h0000, 1'b0, r);
    chk($sformatf("reg %h", a), e, r);
  endtask : rchk

  task automatic reply_chk(input int n);
    int c;
    c = 0;
    @(posedge ref_clk);
    reply_request <= 1'b1;
    @(posedge ref_clk);
    reply_request <= 1'b0;
    #1;
    while (reply_go !== 1'b1 && c < 100)
    begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    chk("reply delay", n * CPM, c);
  endtask : reply_chk

  function automatic logic [1:0] exp_light(input logic [3:0] w, input logic [1:0] p, input logic [7:0] c);
    exp_light[0] = w[0] | p[0] | (w[1] & c[3]) | (p[1] & c[4]);
    exp_light[1] = w[1] | p[1] | (w[0] & c[1]) | (p[0] & c[2]);
  endfunction : exp_light

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    k = $urandom(27);
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk("bit rate", 32'd76800, serial_bit_rate);
    rchk(`ADR_STOP_BITS, `VAL_STOP_BITS);
    rchk(`ADR_DATA_BITS, `VAL_DATA_BITS);
    rchk(`ADR_PARITY, `VAL_PARITY);
    rchk(`ADR_BIT_RATE, `RST_BIT_RATE);
    rchk(`ADR_ANSWER_WAIT, `RST_ANSWER_WAIT);
    rchk(`ADR_IDENTITY, {FW_X10, TYPE_ID});
    bus(1'b0, `ADR_ACTION, 16'h0000, 1'b1, q);
    chk("action read", 16'h0000, q);
    bus(1'b0, 16'h1234, 16'h0000, 1'b1, q);
    bus(1'b1, `ADR_STATION, 16'h00FF, 1'b1, q);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      station_address_switch <= 8'($urandom);
      config_switch_pins <= (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      wall_inputs <= 4'($urandom);
      presence_inputs <= 2'($urandom);
      relay_feedback <= 4'($urandom);
      speed_select_switch <= (i == 7) ? 3'h0 : 3'($urandom);
      repeat (4) @(posedge ref_clk);
      #1;
      chk("light", exp_light(wall_inputs, presence_inputs, config_switch_pins),
          {light_two_demand, light_one_demand});
      chk("modes", {config_switch_pins[0], config_switch_pins[6], config_switch_pins[5], !config_switch_pins[7]},
          {wall_pair_a_latching, wall_pair_b_latching, on_off_light_mode, slat_control});
      chk("rate sw", |speed_select_switch, rate_from_switch);
      rchk(`ADR_STATION, {8'h00, station_address_switch});
      rchk(`ADR_CFG_MIRROR, {8'h00, config_switch_pins});
      rchk(`ADR_CFG_LOW, {8'h00, config_switch_pins});
      rchk(`ADR_INPUT_STATE, {12'h000, wall_inputs});
      rchk(`ADR_RELAY_STATE, {12'h000, relay_feedback});
    end
    for (k = 0; k < 3; k++)
    begin
      cnt[k] = 3 + $urandom % 8;
      @(posedge ref_clk);
      send <= 3'h1 << k;
      repeat (cnt[k]) @(posedge ref_clk);
      send <= 3'h0;
    end
    repeat (3) @(posedge ref_clk);
    for (k = 0; k < 3; k++)
    begin
      rchk(16'(`ADR_RX_COUNT + 2 * k), 16'(cnt[k]));
      rchk(16'(`ADR_RX_COUNT + 2 * k + 1), 16'h0000);
    end
    bus(1'b1, `ADR_BIT_RATE, 16'd1000, 1'b0, q);
    repeat (2) @(posedge ref_clk);
    chk("bit rate", 32'd76800, serial_bit_rate);
    for (k = 0; k < 3; k++)
      rchk(16'(`ADR_RX_COUNT + 2 * k), 16'h0000);
    rchk(`ADR_BIT_RATE, 16'd1000);
    // A non-zero wait lets the defaults action show that it restores the wait.
    bus(1'b1, `ADR_ANSWER_WAIT, 16'h0005, 1'b0, q);
    bus(1'b1, `ADR_ACTION, 16'h05FF, 1'b0, q);
    chk("no action", 4'h0, {boot_req, defaults_req, reload_req, module_reset_req});
    for (k = 0; k < 4; k++)
    begin
      bus(1'b1, `ADR_ACTION, acts[k], 1'b0, q);
      chk("action", 4'h1 << k, {boot_req, defaults_req, reload_req, module_reset_req});
    end
    repeat (20) @(posedge ref_clk);
    chk("bit rate", 32'd10000, serial_bit_rate);
    bus(1'b0, `ADR_UPTIME, 16'h0000, 1'b0, q);
    // The uptime read is sampled 28 cycles after the restart action.
    chk("uptime", 28 / CPS, q);
    rchk(`ADR_BIT_RATE, `RST_BIT_RATE);
    rchk(`ADR_ANSWER_WAIT, 16'h0000);
    reply_chk(0);
    bus(1'b1, `ADR_ANSWER_WAIT, 16'h0002, 1'b0, q);
    reply_chk(2);
    end_sim();
  end
endmodule : modbus_config_io_registers_bench
